// [fsp_status_protect.sv]
`default_nettype none
`include "fsp_params.svh"
module fsp_status_protect #(
  parameter int unsigned SRW_CYCLES = 16,
  parameter logic [3:0] DEF_DUMMY = 4'h8
) (
  // Core clock and reset.
  input wire logic core_clk_i,
  input wire logic srst_i,
  // Serial link.
  input wire logic spi_sck_i,
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  output logic spi_miso_o,
  output logic spi_miso_oe_o,
  // Write protect pin.
  input wire logic wp_n_i,
  // Array engine.
  output fsp_pkg::fsp_array_req_t op_req_o,
  output logic op_start_o,
  output logic op_suspend_o,
  output logic op_resume_o,
  output logic op_abort_o,
  input wire logic op_done_i,
  // Read sequencer.
  input wire logic rd_load_i,
  input wire logic [23:0] rd_start_addr_i,
  input wire logic rd_next_i,
  output logic [23:0] rd_addr_o,
  output fsp_pkg::fsp_read_cfg_t rd_cfg_o,
  // Status view.
  output fsp_pkg::fsp_status_t status_o,
  output logic busy_o
);
  import fsp_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Functions.
  function automatic logic [24:0] prot_size(input logic gran, input logic [2:0] lvl);
    logic [24:0] s;
    s = '0;
    if (lvl == 3'h0) begin
      s = '0;
    end else if (lvl[2:1] == 2'b11) begin
      s = `FSP_ARRAY_BYTES;
    end else if (!gran) begin
      s = `FSP_BLOCK_BYTES << (lvl - 3'h1);
    end else if (lvl[2]) begin
      s = `FSP_SECTOR_BYTES << `FSP_SEC_MAX_SHIFT;
    end else begin
      s = `FSP_SECTOR_BYTES << (lvl - 3'h1);
    end
    return s;
  endfunction

  function automatic logic op_blocked(input logic [7:0] s1, input logic cmp, input logic [24:0] lo,
                                      input logic [24:0] hi);
    logic [24:0] sz;
    logic [24:0] rlo;
    logic [24:0] rhi;
    logic res;
    sz = prot_size(s1[`FSP_S1_GRAN], s1[`FSP_S1_LVL_HI:`FSP_S1_LVL_LO]);
    rlo = s1[`FSP_S1_TB] ? 25'h0 : `FSP_ARRAY_BYTES - sz;
    rhi = s1[`FSP_S1_TB] ? sz : `FSP_ARRAY_BYTES;
    if (sz == 25'h0) begin
      res = cmp;
    end else if (cmp) begin
      res = !((lo >= rlo) && (hi <= rhi));
    end else begin
      res = (lo < rhi) && (hi > rlo);
    end
    return res;
  endfunction

  function automatic logic [24:0] op_span(input fsp_op_kind_t kind);
    logic [24:0] s;
    s = `FSP_PAGE_BYTES;
    case (kind)
      FSP_OP_SECT: s = `FSP_SECTOR_BYTES;
      FSP_OP_BLOCK: s = `FSP_BLOCK_BYTES;
      FSP_OP_CHIP: s = `FSP_ARRAY_BYTES;
      default: s = `FSP_PAGE_BYTES;
    endcase
    return s;
  endfunction

  function automatic logic [23:0] wrap_next(input logic [23:0] a, input fsp_read_cfg_t cfg);
    logic [5:0] low;
    low = a[5:0] + 6'h01;
    if (cfg.enable) begin
      return {a[23:6], (a[5:0] & ~cfg.mask) | (low & cfg.mask)};
    end
    return a + 24'h000001;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Link domain: byte capture and status shift-out.
  logic [2:0] bit_cnt_q;
  logic [6:0] in_sh_q;
  logic first_q;
  logic [1:0] rd_sel_q;
  logic [7:0] sck_byte_q;
  logic sck_tgl_q;
  logic [1:0] s_req_q;
  logic s_ack_q;
  fsp_status_t s_snap_q;
  logic [2:0] out_cnt_q;
  logic [7:0] out_sh_q;
  logic [7:0] sel_byte;
  logic [7:0] in_byte;

  assign in_byte = {in_sh_q, spi_mosi_i};

  always_ff @(posedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      bit_cnt_q <= 3'h0;
      in_sh_q <= 7'h00;
      first_q <= 1'b1;
      rd_sel_q <= 2'b00;
    end else begin
      bit_cnt_q <= bit_cnt_q + 3'h1;
      in_sh_q <= in_byte[6:0];
      if (bit_cnt_q == `FSP_BIT_LAST && first_q) begin
        first_q <= 1'b0;
        case (in_byte)
          `FSP_CMD_RDSR1: rd_sel_q <= 2'b01;
          `FSP_CMD_RDSR2: rd_sel_q <= 2'b10;
          `FSP_CMD_RDSR3: rd_sel_q <= 2'b11;
          default: rd_sel_q <= 2'b00;
        endcase
      end
    end
  end

  always_ff @(posedge spi_sck_i or posedge srst_i) begin
    if (srst_i) begin
      sck_byte_q <= 8'h00;
      sck_tgl_q <= 1'b0;
    end else if (!spi_cs_n_i && bit_cnt_q == `FSP_BIT_LAST) begin
      sck_byte_q <= in_byte;
      sck_tgl_q <= ~sck_tgl_q;
    end
  end

  fsp_status_t snap_q;
  logic req_q;

  always_ff @(posedge spi_sck_i or posedge srst_i) begin
    if (srst_i) begin
      s_req_q <= 2'b00;
      s_ack_q <= 1'b0;
      s_snap_q <= '0;
    end else begin
      s_req_q <= {s_req_q[0], req_q};
      if (s_req_q[1] != s_ack_q) begin
        s_snap_q <= snap_q;
        s_ack_q <= s_req_q[1];
      end
    end
  end

  always_comb begin
    sel_byte = s_snap_q.one;
    case (rd_sel_q)
      2'b10: sel_byte = s_snap_q.two;
      2'b11: sel_byte = s_snap_q.three;
      default: sel_byte = s_snap_q.one;
    endcase
  end

  always_ff @(negedge spi_sck_i or posedge spi_cs_n_i) begin
    if (spi_cs_n_i) begin
      spi_miso_o <= 1'b0;
      spi_miso_oe_o <= 1'b0;
      out_cnt_q <= 3'h0;
      out_sh_q <= 8'h00;
    end else if (rd_sel_q != 2'b00) begin
      spi_miso_oe_o <= 1'b1;
      out_cnt_q <= out_cnt_q + 3'h1;
      if (out_cnt_q == 3'h0) begin
        spi_miso_o <= sel_byte[7];
        out_sh_q <= {sel_byte[6:0], 1'b0};
      end else begin
        spi_miso_o <= out_sh_q[7];
        out_sh_q <= {out_sh_q[6:0], 1'b0};
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: synchronisers.
  logic [3:0] cs_q;
  logic [2:0] tgl_q;
  logic [1:0] wp_q;
  logic [1:0] ack_q;
  logic byte_stb;
  logic frame_end;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      cs_q <= 4'hF;
      tgl_q <= 3'h0;
      wp_q <= 2'b11;
      ack_q <= 2'b00;
    end else begin
      cs_q <= {cs_q[2:0], spi_cs_n_i};
      tgl_q <= {tgl_q[1:0], sck_tgl_q};
      wp_q <= {wp_q[0], wp_n_i};
      ack_q <= {ack_q[0], s_ack_q};
    end
  end

  assign byte_stb = tgl_q[2] ^ tgl_q[1];
  assign frame_end = cs_q[2] & ~cs_q[3];

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: frame collection.
  fsp_state_t state_q;
  logic [2:0] byte_idx_q;
  logic [7:0] opcode_q;
  logic cmd_ok_q;
  logic [7:0] b1_q;
  logic [7:0] b2_q;
  logic [7:0] b3_q;
  logic busy;
  logic busy_pass;

  assign busy = (state_q == FSP_ST_RUN) || (state_q == FSP_ST_NVWR);
  assign busy_pass = (sck_byte_q == `FSP_CMD_RSTEN) || (sck_byte_q == `FSP_CMD_RST) ||
                     (sck_byte_q == `FSP_CMD_SUSP);

  always_ff @(posedge core_clk_i) begin
    if (srst_i || cs_q[2]) begin
      byte_idx_q <= 3'h0;
    end else if (byte_stb && byte_idx_q != `FSP_IDX_FULL) begin
      byte_idx_q <= byte_idx_q + 3'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      opcode_q <= 8'h00;
      cmd_ok_q <= 1'b0;
      b1_q <= 8'h00;
      b2_q <= 8'h00;
      b3_q <= 8'h00;
    end else if (byte_stb) begin
      case (byte_idx_q)
        3'h0: begin
          opcode_q <= sck_byte_q;
          cmd_ok_q <= !busy || busy_pass;
        end
        3'h1: b1_q <= sck_byte_q;
        3'h2: b2_q <= sck_byte_q;
        3'h3: b3_q <= sck_byte_q;
        default: b3_q <= b3_q;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: command execution decode.
  logic [7:0] nv_s1_q;
  logic [7:0] nv_s2_q;
  logic [7:0] s3_q;
  logic wel_q;
  logic vol_en_q;
  logic rst_en_q;
  logic srw_locked;
  logic go;
  logic do_wren;
  logic do_wrdi;
  logic do_srw;
  logic do_srw_vol;
  logic do_srw_nv;
  logic do_op;
  logic do_op_drop;
  logic do_susp;
  logic do_resm;
  logic do_rst;
  fsp_op_kind_t kind_d;
  logic [24:0] op_lo;
  logic [24:0] op_hi;

  assign go = frame_end && cmd_ok_q && byte_idx_q != 3'h0;
  assign srw_locked = nv_s2_q[`FSP_S2_LOCKB] || (nv_s1_q[`FSP_S1_LOCKA] && !wp_q[1]);

  always_comb begin
    do_wren = 1'b0;
    do_wrdi = 1'b0;
    do_srw = 1'b0;
    do_srw_vol = 1'b0;
    do_srw_nv = 1'b0;
    do_susp = 1'b0;
    do_resm = 1'b0;
    do_rst = 1'b0;
    do_op = 1'b0;
    do_op_drop = 1'b0;
    kind_d = FSP_OP_NONE;
    if (go) begin
      case (opcode_q)
        `FSP_CMD_WREN: do_wren = 1'b1;
        `FSP_CMD_WRDI: do_wrdi = 1'b1;
        `FSP_CMD_WRSR: begin
          do_srw = byte_idx_q >= `FSP_IDX_SR1;
          do_srw_vol = do_srw && vol_en_q;
          do_srw_nv = do_srw && !vol_en_q && wel_q && !srw_locked;
        end
        `FSP_CMD_PP: kind_d = (byte_idx_q == `FSP_IDX_FULL) ? FSP_OP_PAGE : FSP_OP_NONE;
        `FSP_CMD_SE: kind_d = (byte_idx_q == `FSP_IDX_FULL) ? FSP_OP_SECT : FSP_OP_NONE;
        `FSP_CMD_BE: kind_d = (byte_idx_q == `FSP_IDX_FULL) ? FSP_OP_BLOCK : FSP_OP_NONE;
        `FSP_CMD_CE: kind_d = FSP_OP_CHIP;
        `FSP_CMD_SECER: kind_d = (byte_idx_q == `FSP_IDX_FULL) ? FSP_OP_SRERASE : FSP_OP_NONE;
        `FSP_CMD_SECPG: kind_d = (byte_idx_q == `FSP_IDX_FULL) ? FSP_OP_SRPROG : FSP_OP_NONE;
        `FSP_CMD_SUSP: do_susp = state_q == FSP_ST_RUN;
        `FSP_CMD_RESM: do_resm = state_q == FSP_ST_SUSP;
        `FSP_CMD_RST: do_rst = rst_en_q;
        default: do_wren = 1'b0;
      endcase
    end
    op_lo = (kind_d == FSP_OP_CHIP) ? 25'h0 :
            ({1'b0, b1_q, b2_q, b3_q} & (`FSP_ARRAY_BYTES - 25'h1) & ~(op_span(kind_d) - 25'h1));
    op_hi = op_lo + op_span(kind_d);
    if (kind_d != FSP_OP_NONE && wel_q && state_q == FSP_ST_IDLE) begin
      if ((kind_d == FSP_OP_SRPROG) || (kind_d == FSP_OP_SRERASE) ||
          !op_blocked(nv_s1_q, nv_s2_q[`FSP_S2_CMP], op_lo, op_hi)) begin
        do_op = 1'b1;
      end else begin
        do_op_drop = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: write enable latch and one-shot enables.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      wel_q <= 1'b0;
    end else if (do_wren || do_resm) begin
      wel_q <= 1'b1;
    end else if (do_wrdi || do_srw || do_op || do_rst) begin
      wel_q <= 1'b0;
    end else if (do_op_drop) begin
      wel_q <= 1'b0;
    end else if (do_susp) begin
      wel_q <= 1'b0;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      vol_en_q <= 1'b0;
      rst_en_q <= 1'b0;
    end else if (go) begin
      vol_en_q <= opcode_q == `FSP_CMD_VWREN;
      rst_en_q <= opcode_q == `FSP_CMD_RSTEN;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: embedded operation state.
  logic [15:0] cnt_q;
  logic srw_commit;

  assign srw_commit = (state_q == FSP_ST_NVWR) && (cnt_q == 16'(SRW_CYCLES - 1));

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      state_q <= FSP_ST_IDLE;
      cnt_q <= 16'h0000;
    end else begin
      cnt_q <= (state_q == FSP_ST_NVWR) ? cnt_q + 16'h0001 : 16'h0000;
      case (state_q)
        FSP_ST_IDLE: begin
          if (do_op) begin
            state_q <= FSP_ST_RUN;
          end else if (do_srw_nv) begin
            state_q <= FSP_ST_NVWR;
          end
        end
        FSP_ST_RUN: begin
          if (do_rst || op_done_i) begin
            state_q <= FSP_ST_IDLE;
          end else if (do_susp) begin
            state_q <= FSP_ST_SUSP;
          end
        end
        FSP_ST_SUSP: begin
          if (do_rst) begin
            state_q <= FSP_ST_IDLE;
          end else if (do_resm) begin
            state_q <= FSP_ST_RUN;
          end
        end
        FSP_ST_NVWR: begin
          if (do_rst || srw_commit) begin
            state_q <= FSP_ST_IDLE;
          end
        end
        default: state_q <= FSP_ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: status and configuration bits.
  logic [7:0] pend_s1_q;
  logic [7:0] pend_s2_q;
  logic [7:0] new_s2;

  assign new_s2 = (byte_idx_q >= `FSP_IDX_SR2) ? b2_q : nv_s2_q;

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      nv_s1_q <= 8'h00;
      nv_s2_q <= 8'h00;
      pend_s1_q <= 8'h00;
      pend_s2_q <= 8'h00;
    end else if (do_srw_vol && !srw_locked) begin
      nv_s1_q <= b1_q & `FSP_S1_WR_MASK;
      nv_s2_q <= (new_s2 & `FSP_S2_WR_MASK) | ((new_s2 | nv_s2_q) & `FSP_S2_LB_MASK);
    end else if (do_srw_nv) begin
      pend_s1_q <= b1_q;
      pend_s2_q <= new_s2;
    end else if (srw_commit) begin
      nv_s1_q <= pend_s1_q & `FSP_S1_WR_MASK;
      nv_s2_q <= (pend_s2_q & `FSP_S2_WR_MASK) | ((pend_s2_q | nv_s2_q) & `FSP_S2_LB_MASK);
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i || do_rst) begin
      s3_q <= `FSP_S3_RESET;
    end else if (do_srw_vol && byte_idx_q == `FSP_IDX_FULL) begin
      s3_q <= b3_q & `FSP_S3_WR_MASK;
    end
  end

  fsp_status_t live;

  always_comb begin
    live.one = nv_s1_q;
    live.one[`FSP_S1_BUSY] = busy;
    live.one[`FSP_S1_WEL] = wel_q;
    live.two = nv_s2_q;
    live.two[`FSP_S2_LB0] = 1'b1;
    live.two[`FSP_S2_SUS] = state_q == FSP_ST_SUSP;
    live.three = s3_q;
  end

  // Status snapshot handed to the link domain by a request/acknowledge toggle pair.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      snap_q <= '0;
      req_q <= 1'b0;
    end else if (req_q == ack_q[1] && snap_q != live) begin
      snap_q <= live;
      req_q <= ~req_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: read configuration and wrapped address.
  fsp_read_cfg_t cfg_d;
  logic [6:0] wrap_bytes;
  logic [3:0] lc;

  assign wrap_bytes = `FSP_WRAP_BASE << s3_q[`FSP_S3_WLEN_HI:`FSP_S3_WLEN_LO];
  assign lc = s3_q[`FSP_S3_LC_HI:`FSP_S3_LC_LO];

  always_comb begin
    cfg_d.enable = !s3_q[`FSP_S3_WDIS];
    cfg_d.mask = 6'(wrap_bytes - 7'h01);
    cfg_d.dummy = (lc == `FSP_LC_OFF) ? DEF_DUMMY : lc;
  end

  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      rd_cfg_o <= '0;
      rd_addr_o <= 24'h000000;
    end else begin
      rd_cfg_o <= cfg_d;
      if (rd_load_i) begin
        rd_addr_o <= rd_start_addr_i;
      end else if (rd_next_i) begin
        rd_addr_o <= wrap_next(rd_addr_o, rd_cfg_o);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Core domain: outputs to the array engine and status view.
  always_ff @(posedge core_clk_i) begin
    if (srst_i) begin
      op_req_o <= '0;
      op_start_o <= 1'b0;
      op_suspend_o <= 1'b0;
      op_resume_o <= 1'b0;
      op_abort_o <= 1'b0;
      status_o <= '0;
      busy_o <= 1'b0;
    end else begin
      if (do_op) begin
        op_req_o <= '{kind: kind_d, addr: op_lo[23:0]};
      end
      op_start_o <= do_op;
      op_suspend_o <= do_susp;
      op_resume_o <= do_resm;
      op_abort_o <= do_rst && (state_q == FSP_ST_RUN || state_q == FSP_ST_SUSP);
      status_o <= live;
      busy_o <= busy;
    end
  end

endmodule : fsp_status_protect
`default_nettype wire

// [fsp_params.svh]
`ifndef FSP_PARAMS_SVH
`define FSP_PARAMS_SVH
// Command opcodes.
`define FSP_CMD_WREN 8'h06
`define FSP_CMD_WRDI 8'h04
`define FSP_CMD_VWREN 8'h50
`define FSP_CMD_RDSR1 8'h05
`define FSP_CMD_RDSR2 8'h35
`define FSP_CMD_RDSR3 8'h33
`define FSP_CMD_WRSR 8'h01
`define FSP_CMD_PP 8'h02
`define FSP_CMD_SE 8'h20
`define FSP_CMD_BE 8'hD8
`define FSP_CMD_CE 8'hC7
`define FSP_CMD_SECER 8'h44
`define FSP_CMD_SECPG 8'h42
`define FSP_CMD_SUSP 8'h75
`define FSP_CMD_RESM 8'h7A
`define FSP_CMD_RSTEN 8'h66
`define FSP_CMD_RST 8'h99
// Status one fields.
`define FSP_S1_BUSY 0
`define FSP_S1_WEL 1
`define FSP_S1_LVL_LO 2
`define FSP_S1_LVL_HI 4
`define FSP_S1_TB 5
`define FSP_S1_GRAN 6
`define FSP_S1_LOCKA 7
`define FSP_S1_WR_MASK 8'hFC
// Status two fields.
`define FSP_S2_LOCKB 0
`define FSP_S2_LB0 2
`define FSP_S2_CMP 6
`define FSP_S2_SUS 7
`define FSP_S2_WR_MASK 8'h43
`define FSP_S2_LB_MASK 8'h38
// Status three fields and reset value.
`define FSP_S3_LC_LO 0
`define FSP_S3_LC_HI 3
`define FSP_S3_WDIS 4
`define FSP_S3_WLEN_LO 5
`define FSP_S3_WLEN_HI 6
`define FSP_S3_WR_MASK 8'h7F
`define FSP_S3_RESET 8'h70
`define FSP_LC_OFF 4'h0
// Frame byte counts.
`define FSP_IDX_SR1 3'h2
`define FSP_IDX_SR2 3'h3
`define FSP_IDX_FULL 3'h4
`define FSP_BIT_LAST 3'h7
// Array geometry in bytes.
`define FSP_ARRAY_BYTES 25'h0200000
`define FSP_BLOCK_BYTES 25'h0010000
`define FSP_SECTOR_BYTES 25'h0001000
`define FSP_PAGE_BYTES 25'h0000100
`define FSP_SEC_MAX_SHIFT 3'h3
`define FSP_WRAP_BASE 7'h08
`endif

// [fsp_pkg.sv]
`default_nettype none
package fsp_pkg;
  typedef enum logic [1:0] {
    FSP_ST_IDLE = 2'b00,
    FSP_ST_RUN = 2'b01,
    FSP_ST_SUSP = 2'b10,
    FSP_ST_NVWR = 2'b11
  } fsp_state_t;
  typedef enum logic [2:0] {
    FSP_OP_NONE = 3'b000,
    FSP_OP_PAGE = 3'b001,
    FSP_OP_SECT = 3'b010,
    FSP_OP_BLOCK = 3'b011,
    FSP_OP_CHIP = 3'b100,
    FSP_OP_SRPROG = 3'b101,
    FSP_OP_SRERASE = 3'b110
  } fsp_op_kind_t;
  typedef struct packed {
    fsp_op_kind_t kind;
    logic [23:0] addr;
  } fsp_array_req_t;
  typedef struct packed {
    logic [7:0] three;
    logic [7:0] two;
    logic [7:0] one;
  } fsp_status_t;
  typedef struct packed {
    logic enable;
    logic [5:0] mask;
    logic [3:0] dummy;
  } fsp_read_cfg_t;
endpackage : fsp_pkg
`default_nettype wire

// [fsp_status_protect_end.sv]
`default_nettype none
`default_nettype wire

// [fsp_host_model.sv]
`default_nettype none
module fsp_host_model (
  // Serial link toward the device.
  output logic sck_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b0;
  end
  // Sends whole bytes top bit first and keeps the last byte returned.
  task automatic frame(input logic [7:0] q[$], output logic [7:0] rx);
    rx = 8'h00;
    cs_n_o = 1'b0;
    foreach (q[b]) begin
      for (int i = 7; i >= 0; i--) begin
        mosi_o = q[b][i];
        #62.5 sck_o = 1'b1;
        rx = {rx[6:0], miso_i};
        #62.5 sck_o = 1'b0;
      end
    end
    #62.5 cs_n_o = 1'b1;
    mosi_o = ~mosi_o;
    #250;
  endtask
endmodule // fsp_host_model
`default_nettype wire

// [fsp_status_protect_sva.sv]
`default_nettype none
module fsp_status_protect_sva
  import fsp_pkg::*;
#(
  parameter int unsigned SRW_CYCLES = 16,
  parameter logic [3:0] DEF_DUMMY = 4'h8
) (
  // Clocks and reset.
  input wire logic core_clk_i,
  input wire logic srst_i,
  input wire logic spi_sck_i,
  // Serial link.
  input wire logic spi_cs_n_i,
  input wire logic spi_mosi_i,
  input wire logic spi_miso_o,
  input wire logic spi_miso_oe_o,
  input wire logic wp_n_i,
  // Array engine.
  input wire fsp_pkg::fsp_array_req_t op_req_o,
  input wire logic op_start_o,
  input wire logic op_suspend_o,
  input wire logic op_resume_o,
  input wire logic op_abort_o,
  input wire logic op_done_i,
  // Read side and status.
  input wire logic rd_load_i,
  input wire logic [23:0] rd_start_addr_i,
  input wire logic rd_next_i,
  input wire logic [23:0] rd_addr_o,
  input wire fsp_pkg::fsp_read_cfg_t rd_cfg_o,
  input wire fsp_pkg::fsp_status_t status_o,
  input wire logic busy_o
);
  logic [1:0] settle_q;
  ////////////////////////////////////////
  // Counts cycles that status three has held still.
  always_ff @(posedge core_clk_i) begin
    if (srst_i || status_o.three != $past(status_o.three)) begin
      settle_q <= 2'h0;
    end else if (settle_q != 2'h3) begin
      settle_q <= settle_q + 2'h1;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (srst_i);
  sequence s_start_done;
    op_start_o ##1 op_done_i;
  endsequence
  sequence s_settled;
    settle_q == 2'h3;
  endsequence
  property p_start_busy;
    op_start_o |-> ##1 busy_o;
  endproperty
  property p_done_clear;
    s_start_done |-> ##[1:3] !busy_o;
  endproperty
  property p_start_wel;
    op_start_o |-> ##[0:2] !status_o.one[1];
  endproperty
  property p_busy_refuse;
    busy_o |-> !op_start_o;
  endproperty
  property p_susp_wel;
    op_suspend_o |-> ##[0:2] !status_o.one[1];
  endproperty
  property p_resm_wel;
    op_resume_o |-> ##[0:2] status_o.one[1];
  endproperty
  property p_cfg_dummy;
    s_settled |-> rd_cfg_o.dummy == (status_o.three[3:0] == 4'h0 ? DEF_DUMMY : status_o.three[3:0]);
  endproperty
  property p_cfg_wrap;
    s_settled |-> rd_cfg_o.enable == !status_o.three[4];
  endproperty
  property p_rd_wrap;
    rd_next_i && !rd_load_i && rd_cfg_o.enable |=> rd_addr_o[23:6] == $past(rd_addr_o[23:6]);
  endproperty
  property p_oe_idle;
    spi_cs_n_i |-> !spi_miso_oe_o;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("busy missing after start");
  a_done_clear: assert property (p_done_clear) else $error("busy held after done");
  a_start_wel: assert property (p_start_wel) else $error("latch held after start");
  a_busy_refuse: assert property (p_busy_refuse) else $error("start while busy");
  a_susp_wel: assert property (p_susp_wel) else $error("latch held after suspend");
  a_resm_wel: assert property (p_resm_wel) else $error("latch not set on resume");
  a_cfg_dummy: assert property (p_cfg_dummy) else $error("dummy count wrong");
  a_cfg_wrap: assert property (p_cfg_wrap) else $error("wrap enable wrong");
  a_rd_wrap: assert property (p_rd_wrap) else $error("wrap left window");
  a_oe_idle: assert property (p_oe_idle) else $error("output driven while deselected");
endmodule // fsp_status_protect_sva
`default_nettype wire

// [test_fsp_status_protect.sv]
`default_nettype none
module test_fsp_status_protect;
  timeunit 1ns;
  timeprecision 100ps;
  import fsp_pkg::*;
  localparam logic [3:0] DEF = 4'h8;
  logic core_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic sck, cs_n, mosi, miso, miso_oe, op_start, op_susp, op_resm, busy, op_done = 1'b0;
  logic rd_load = 1'b0, rd_next = 1'b0, auto_done = 1'b0, done_req = 1'b0, wp_n = 1'b1, op_abort;
  logic [23:0] rd_start = 24'h000000, rd_addr, a;
  logic [7:0] rx;
  logic [31:0] seed = 32'h2FD572C7;
  fsp_array_req_t op_req;
  fsp_read_cfg_t rd_cfg;
  fsp_status_t status;
  int num_errors = 0, checked = 0, starts = 0, susps = 0, resms = 0, aborts = 0;
  always #12.5 core_clk_i = ~core_clk_i;
  always @(posedge core_clk_i) begin
    starts += int'(op_start === 1'b1);
    susps += int'(op_susp === 1'b1);
    resms += int'(op_resm === 1'b1);
    aborts += int'(op_abort === 1'b1);
    op_done <= #1 auto_done ? op_start : done_req;
  end
  fsp_status_protect #(.SRW_CYCLES(4), .DEF_DUMMY(DEF)) uut (
    .core_clk_i(core_clk_i), .srst_i(srst_i), .spi_sck_i(sck), .spi_cs_n_i(cs_n), .spi_mosi_i(mosi),
    .spi_miso_o(miso), .spi_miso_oe_o(miso_oe), .wp_n_i(wp_n), .op_req_o(op_req), .op_start_o(op_start),
    .op_suspend_o(op_susp), .op_resume_o(op_resm), .op_abort_o(op_abort), .op_done_i(op_done), .rd_load_i(rd_load),
    .rd_start_addr_i(rd_start), .rd_next_i(rd_next), .rd_addr_o(rd_addr), .rd_cfg_o(rd_cfg),
    .status_o(status), .busy_o(busy));
  fsp_host_model host (.sck_o(sck), .cs_n_o(cs_n), .mosi_o(mosi), .miso_i(miso));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic final_report;
    $display("mismatches %0d comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic cmd(input logic [7:0] q[$]);
    host.frame(q, rx);
    cyc(12);
  endtask
  task automatic idle;
    for (int i = 0; i < 400 && busy !== 1'b0; i++) cyc(1);
    if (busy !== 1'b0) begin
      chk(busy, 0);
      final_report;
    end
    cyc(2);
  endtask
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [23:0] wrap_next(input logic [23:0] x, input logic [1:0] k);
    logic [23:0] m;
    m = (24'h000008 << k) - 24'h000001;
    return (x & ~m) | ((x + 24'h000001) & m);
  endfunction
  ////////////////////////////////////////
  initial begin
    fsp_op_kind_t ek [4] = '{FSP_OP_PAGE, FSP_OP_SECT, FSP_OP_BLOCK, FSP_OP_SRPROG};
    logic [7:0] op [4] = '{8'h02, 8'h20, 8'hD8, 8'h42};
    logic [23:0] msk [4] = '{24'h0000FF, 24'h000FFF, 24'h00FFFF, 24'h0000FF};
    logic [7:0] s3;
    cyc(12);
    srst_i = 1'b0;
    cyc(6);
    chk(status, {8'h70, 8'h04, 8'h00});
    chk(rd_cfg, {1'b0, 6'h3F, DEF});
    host.frame('{8'h33, 8'h00}, rx);
    chk(rx, 8'h70);
    cmd('{8'h06});
    chk(status.one[1], 1);
    host.frame('{8'h05, 8'h00}, rx);
    chk(rx, 8'h02);
    cmd('{8'h04});
    chk(status.one[1], 0);
    for (int i = 0; i < 4; i++) begin
      seed = lfsr(seed);
      a = seed[23:0] & 24'h1FFFFF;
      cmd('{8'h06});
      cmd('{op[i], a[23:16], a[15:8], a[7:0]});
      chk(op_req, {ek[i], a & ~msk[i]});
      chk({busy, status.one[1:0]}, 3'b101);
      cmd('{8'h06});
      chk(status.one[1], 0);
      cmd('{8'h75});
      chk({susps, status.two[7], status.one[1]}, {i + 1, 2'b10});
      cmd('{8'h7A});
      chk({resms, status.one[1], busy}, {i + 1, 2'b11});
      done_req = 1'b1;
      cyc(1);
      done_req = 1'b0;
      cyc(4);
      chk({busy, status.one[0]}, 2'b00);
    end
    cmd('{8'h06});
    cmd('{8'h01, 8'h18});
    idle;
    chk(status.one[4:2], 3'h6);
    cmd('{8'h06});
    cmd('{8'h02, a[23:16], a[15:8], a[7:0]});
    chk(starts, 4);
    chk(status.one[1], 0);
    cmd('{8'h06});
    cmd('{8'h01, 8'h18, 8'h40});
    idle;
    chk(status.two[6], 1);
    host.frame('{8'h35, 8'h00}, rx);
    chk(rx, 8'h44);
    auto_done = 1'b1;
    cmd('{8'h06});
    cmd('{8'h02, a[23:16], a[15:8], a[7:0]});
    chk(starts, 5);
    auto_done = 1'b0;
    cmd('{8'h06});
    cmd('{8'h01, 8'h80});
    idle;
    wp_n = 1'b0;
    cmd('{8'h06});
    cmd('{8'h01, 8'h1C});
    idle;
    chk(status.one[7:1], 7'h40);
    wp_n = 1'b1;
    for (int k = 0; k < 4; k++) begin
      seed = lfsr(seed);
      s3 = {1'b0, k[1:0], 1'b0, seed[3:0]};
      cmd('{8'h50});
      cmd('{8'h01, 8'h00, 8'h00, s3});
      idle;
      chk(status.three, s3);
      chk(rd_cfg.dummy, s3[3:0] == 4'h0 ? DEF : s3[3:0]);
      a = seed[31:8];
      rd_start = a;
      rd_load = 1'b1;
      cyc(1);
      rd_load = 1'b0;
      rd_next = 1'b1;
      for (int j = 0; j < 70; j++) begin
        cyc(1);
        a = wrap_next(a, k[1:0]);
        chk(rd_addr, a);
      end
      rd_next = 1'b0;
    end
    cmd('{8'h06});
    cmd('{8'hC7});
    chk({op_req, busy}, {FSP_OP_CHIP, 24'h000000, 1'b1});
    cmd('{8'h66});
    cmd('{8'h99});
    chk({aborts[1:0], busy, status.three}, {2'h1, 1'b0, 8'h70});
    final_report;
  end
endmodule // test_fsp_status_protect
bind fsp_status_protect fsp_status_protect_sva #(.SRW_CYCLES(SRW_CYCLES), .DEF_DUMMY(DEF_DUMMY)) u_sva (
  .core_clk_i(core_clk_i), .srst_i(srst_i), .spi_sck_i(spi_sck_i), .spi_cs_n_i(spi_cs_n_i),
  .spi_mosi_i(spi_mosi_i), .spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .wp_n_i(wp_n_i),
  .op_req_o(op_req_o), .op_start_o(op_start_o), .op_suspend_o(op_suspend_o), .op_resume_o(op_resume_o),
  .op_abort_o(op_abort_o), .op_done_i(op_done_i), .rd_load_i(rd_load_i), .rd_start_addr_i(rd_start_addr_i),
  .rd_next_i(rd_next_i), .rd_addr_o(rd_addr_o), .rd_cfg_o(rd_cfg_o), .status_o(status_o), .busy_o(busy_o));
`default_nettype wire
